// ==== rtv_chk.sv ====
// assertions for the time and alarm value registers
// assumes it is bound to rtv_value_regs on one clock
module rtv_chk
	import rtv_pkg::*;
(
	// watched ports
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [15:0] o_time_weekday_hour,
	input wire logic [15:0] o_time_minute_second,
	input wire logic [15:0] o_alarm_month_day,
	input wire logic [2:0] o_weekday_digit,
	input wire logic [2:0] o_minute_tens_digit,
	input wire logic [3:0] o_second_ones_digit,
	input wire logic o_clock_write_enable,
	input wire logic [1:0] o_alarm_window_pointer
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	wire logic rq = i_avs_read | i_avs_write;
	wire logic done = rq & !o_avs_waitrequest & i_ce;
	wire logic win = done && i_avs_address == RTV_OFS_ALARM_WIN && i_avs_byteenable[1];
	one_wait_a: assert property (rq && o_avs_waitrequest && i_ce |=>
		o_avs_waitrequest == (rq && !i_ce)) else $error("no answer after one wait");
	stall_a: assert property (rq && !i_ce |-> o_avs_waitrequest)
		else $error("answer while frozen");
	idle_a: assert property (!rq |-> !o_avs_waitrequest) else $error("wait while idle");
	hi_zero_a: assert property (o_avs_readdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	wh_mask_a: assert property ((o_time_weekday_hour & ~RTV_WH_MASK) == 16'h0000)
		else $error("weekday hour spare bits");
	md_mask_a: assert property ((o_alarm_month_day & ~RTV_MD_MASK) == 16'h0000)
		else $error("month day spare bits");
	wday_a: assert property (o_weekday_digit == o_time_weekday_hour[10:8])
		else $error("weekday slice wrong");
	ms_slice_a: assert property ({o_minute_tens_digit, o_second_ones_digit} ==
		{o_time_minute_second[14:12], o_time_minute_second[3:0]}) else $error("min sec slice");
	gate_a: assert property (done && i_avs_write && i_avs_address == RTV_OFS_TIME_WH &&
		!o_clock_write_enable |=> $stable(o_time_weekday_hour)) else $error("gated write landed");
	ptr_a: assert property (win |=> o_alarm_window_pointer ==
		($past(o_alarm_window_pointer) == 2'h0 ? 2'h0 : $past(o_alarm_window_pointer) - 2'h1))
		else $error("pointer step wrong");
	cover property (rq && !i_ce);
	cover property (done && i_avs_read);
	cover property (win && o_alarm_window_pointer == 2'h2);
	cover property (done && i_avs_write && !o_clock_write_enable);
endmodule : rtv_chk

bind rtv_value_regs rtv_chk rtv_chk_i (.*);

// ==== rtv_pkg.sv ====
// constants for the clock time and alarm value register block
// assumes a 32-bit avalon-mm slave port with byte addresses
package rtv_pkg;

	// register byte offsets
	localparam logic [4:0] RTV_OFS_TIME_WH = 5'h00;
	localparam logic [4:0] RTV_OFS_TIME_MS = 5'h04;
	localparam logic [4:0] RTV_OFS_ALARM_WIN = 5'h08;
	localparam logic [4:0] RTV_OFS_CTRL = 5'h0C;

	// weekday/hour field positions and widths
	localparam int RTV_WDAY_LSB = 8;
	localparam int RTV_WDAY_W = 3;
	localparam int RTV_HRTEN_LSB = 4;
	localparam int RTV_HRTEN_W = 2;
	localparam int RTV_HRONE_LSB = 0;
	localparam int RTV_HRONE_W = 4;

	// minute/second field positions and widths
	localparam int RTV_MINTEN_LSB = 12;
	localparam int RTV_MINTEN_W = 3;
	localparam int RTV_MINONE_LSB = 8;
	localparam int RTV_MINONE_W = 4;
	localparam int RTV_SECTEN_LSB = 4;
	localparam int RTV_SECTEN_W = 3;
	localparam int RTV_SECONE_LSB = 0;
	localparam int RTV_SECONE_W = 4;

	// month/day field positions
	localparam int RTV_MTHTEN_LSB = 12;
	localparam int RTV_MTHONE_LSB = 8;
	localparam int RTV_DAYTEN_LSB = 4;
	localparam int RTV_DAYONE_LSB = 0;

	// implemented bits of each value word, the rest read as zero
	localparam logic [15:0] RTV_WH_MASK = 16'h073F;
	localparam logic [15:0] RTV_MS_MASK = 16'h7F7F;
	localparam logic [15:0] RTV_MD_MASK = 16'h1F3F;

	// control word fields
	localparam int RTV_CTRL_WREN_BIT = 0;
	localparam int RTV_CTRL_PTR_LSB = 8;

	// alarm window pointer codes
	localparam logic [1:0] RTV_PTR_MS = 2'h0;
	localparam logic [1:0] RTV_PTR_WH = 2'h1;
	localparam logic [1:0] RTV_PTR_MD = 2'h2;

	localparam logic [15:0] RTV_WORD_RESET = 16'h0000;

endpackage : rtv_pkg

// ==== rtv_value_regs.sv ====
// time-of-day and alarm-match value registers of the real time calendar
// assumes an avalon-mm master on the same clock, one request at a time
// Summary of operation
// - weekday digit is bits 10..8 of time and alarm weekday/hour words
// - hour tens digit is bits 5..4 of the weekday/hour words
// - hour ones digit is bits 3..0 of the weekday/hour words
// - minute tens digit is bits 14..12 of the minute/second words
// - minute ones digit is bits 11..8 of the minute/second words
// - second tens digit is bits 6..4 of the minute/second words
// - second ones digit is bits 3..0 of the minute/second words
// - alarm month tens digit is the single bit 12
// - alarm month ones digit is bits 11..8
// - alarm day tens digit is bits 5..4
// - alarm day ones digit is bits 3..0
// - weekday/hour and alarm month/day writes need clock write enable set
// - unimplemented bit positions always read as zero
// - value fields hold no meaningful value until software loads them
// - window pointer selects alarm word, steps down on upper-half access to zero
module rtv_value_regs
	import rtv_pkg::*;
(
	// clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// avalon-mm slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// value words towards the calendar logic
	output logic [15:0] o_time_weekday_hour,
	output logic [15:0] o_time_minute_second,
	output logic [15:0] o_alarm_month_day,
	output logic [15:0] o_alarm_weekday_hour,
	output logic [15:0] o_alarm_minute_second,
	// time digits
	output logic [2:0] o_weekday_digit,
	output logic [1:0] o_hour_tens_digit,
	output logic [3:0] o_hour_ones_digit,
	output logic [2:0] o_minute_tens_digit,
	output logic [3:0] o_minute_ones_digit,
	output logic [2:0] o_second_tens_digit,
	output logic [3:0] o_second_ones_digit,
	// control state
	output logic o_clock_write_enable,
	output logic [1:0] o_alarm_window_pointer
);

	typedef struct packed
	{
		logic [15:0] tm_wh;
		logic [15:0] tm_ms;
		logic [15:0] al_md;
		logic [15:0] al_wh;
		logic [15:0] al_ms;
		logic wren;
		logic [1:0] ptr;
		logic ack;
		logic [31:0] rdata;
	} rtv_state_t;

	localparam rtv_state_t RTV_STATE_RESET = '{
		tm_wh: RTV_WORD_RESET,
		tm_ms: RTV_WORD_RESET,
		al_md: RTV_WORD_RESET,
		al_wh: RTV_WORD_RESET,
		al_ms: RTV_WORD_RESET,
		wren: 1'b0,
		ptr: RTV_PTR_MS,
		ack: 1'b0,
		rdata: 32'h0000_0000
	};

	rtv_state_t state_q;
	rtv_state_t state_d;

	// byte-lane merge of a 16-bit value word, unimplemented bits forced low
	function automatic logic [15:0] rtv_merge
	(
		input logic [15:0] old_word,
		input logic [15:0] wr_word,
		input logic [1:0] lanes,
		input logic [15:0] mask
	);
		logic [15:0] res;
		res = old_word;
		if (lanes[1])
		begin
			res[15:8] = wr_word[15:8];
		end
		if (lanes[0])
		begin
			res[7:0] = wr_word[7:0];
		end
		rtv_merge = res & mask;
	endfunction : rtv_merge

	// alarm word currently shown through the window
	function automatic logic [15:0] rtv_window
	(
		input rtv_state_t st
	);
		case (st.ptr)
			RTV_PTR_MS: rtv_window = st.al_ms;
			RTV_PTR_WH: rtv_window = st.al_wh;
			RTV_PTR_MD: rtv_window = st.al_md;
			default: rtv_window = RTV_WORD_RESET;
		endcase
	endfunction : rtv_window

	logic req;
	logic first;
	logic done;
	logic [15:0] wr_word;
	logic [1:0] wr_lanes;
	logic [31:0] rd_word;

	assign req = i_avs_read | i_avs_write;
	assign first = req & ~state_q.ack;
	assign done = req & state_q.ack;
	assign wr_word = i_avs_writedata[15:0];
	assign wr_lanes = i_avs_byteenable[1:0];

	// read mux, unmapped offsets read zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (i_avs_address)
			RTV_OFS_TIME_WH: rd_word[15:0] = state_q.tm_wh & RTV_WH_MASK;
			RTV_OFS_TIME_MS: rd_word[15:0] = state_q.tm_ms & RTV_MS_MASK;
			RTV_OFS_ALARM_WIN: rd_word[15:0] = rtv_window(state_q);
			RTV_OFS_CTRL:
			begin
				rd_word[RTV_CTRL_WREN_BIT] = state_q.wren;
				rd_word[RTV_CTRL_PTR_LSB +: 2] = state_q.ptr;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		state_d = state_q;
		// every access waits one cycle with i_ce high, then completes
		state_d.ack = first;
		if (first & i_avs_read)
		begin
			state_d.rdata = rd_word;
		end
		if (done & i_avs_write)
		begin
			case (i_avs_address)
				RTV_OFS_TIME_WH:
				begin
					if (state_q.wren)
					begin
						state_d.tm_wh = rtv_merge(state_q.tm_wh, wr_word, wr_lanes,
							RTV_WH_MASK);
					end
				end
				RTV_OFS_TIME_MS:
				begin
					state_d.tm_ms = rtv_merge(state_q.tm_ms, wr_word, wr_lanes,
						RTV_MS_MASK);
				end
				RTV_OFS_ALARM_WIN:
				begin
					case (state_q.ptr)
						RTV_PTR_MS:
						begin
							state_d.al_ms = rtv_merge(state_q.al_ms, wr_word, wr_lanes,
								RTV_MS_MASK);
						end
						RTV_PTR_WH:
						begin
							if (state_q.wren)
							begin
								state_d.al_wh = rtv_merge(state_q.al_wh, wr_word,
									wr_lanes, RTV_WH_MASK);
							end
						end
						RTV_PTR_MD:
						begin
							if (state_q.wren)
							begin
								state_d.al_md = rtv_merge(state_q.al_md, wr_word,
									wr_lanes, RTV_MD_MASK);
							end
						end
						default:
						begin
							state_d.al_ms = state_q.al_ms;
						end
					endcase
				end
				RTV_OFS_CTRL:
				begin
					if (i_avs_byteenable[0])
					begin
						state_d.wren = i_avs_writedata[RTV_CTRL_WREN_BIT];
					end
					if (i_avs_byteenable[1])
					begin
						state_d.ptr = i_avs_writedata[RTV_CTRL_PTR_LSB +: 2];
					end
				end
				default:
				begin
					state_d.wren = state_q.wren;
				end
			endcase
		end
		// upper-half window access steps the pointer down, stopping at zero
		if (done && (i_avs_address == RTV_OFS_ALARM_WIN) && i_avs_byteenable[1]
			&& (state_q.ptr != RTV_PTR_MS))
		begin
			state_d.ptr = state_q.ptr - 2'h1;
		end
	end

	// value words clear at reset though software must still load them
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			state_q <= RTV_STATE_RESET;
		end
		else if (i_ce)
		begin
			state_q <= state_d;
		end
	end

	// bus answer, held off while the clock enable freezes the state
	assign o_avs_waitrequest = req & (~state_q.ack | ~i_ce);
	assign o_avs_readdata = state_q.rdata;

	// value words
	assign o_time_weekday_hour = state_q.tm_wh;
	assign o_time_minute_second = state_q.tm_ms;
	assign o_alarm_month_day = state_q.al_md;
	assign o_alarm_weekday_hour = state_q.al_wh;
	assign o_alarm_minute_second = state_q.al_ms;

	// time digits
	assign o_weekday_digit = state_q.tm_wh[RTV_WDAY_LSB +: RTV_WDAY_W];
	assign o_hour_tens_digit = state_q.tm_wh[RTV_HRTEN_LSB +: RTV_HRTEN_W];
	assign o_hour_ones_digit = state_q.tm_wh[RTV_HRONE_LSB +: RTV_HRONE_W];
	assign o_minute_tens_digit = state_q.tm_ms[RTV_MINTEN_LSB +: RTV_MINTEN_W];
	assign o_minute_ones_digit = state_q.tm_ms[RTV_MINONE_LSB +: RTV_MINONE_W];
	assign o_second_tens_digit = state_q.tm_ms[RTV_SECTEN_LSB +: RTV_SECTEN_W];
	assign o_second_ones_digit = state_q.tm_ms[RTV_SECONE_LSB +: RTV_SECONE_W];

	// control state
	assign o_clock_write_enable = state_q.wren;
	assign o_alarm_window_pointer = state_q.ptr;

endmodule : rtv_value_regs

// ==== tb_top.sv ====
// self-checking bench for the time and alarm value registers
// assumes one 10 MHz clock and avalon-mm access
module tb_top
	import rtv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, wq, wen, ce = 1;
	logic [4:0] adr = 5'h00;
	logic [31:0] wd = 32'h0, rdd;
	logic [3:0] be = 4'h0, bv, so, ho, mo;
	logic [15:0] v, x, tw = 16'h0, tm = 16'h0, twh, tms, amd, awh, ams;
	logic [15:0] a [3];
	logic [2:0] wday, mt, st;
	logic [1:0] ptr, ht;
	int err_count = 0, n_checks = 0, seed = 32'hc6ef5afc;
	always #50 clk = ~clk;
	always @(posedge clk)
		ce <= $random(seed) % 4 != 0;
	rtv_value_regs rtv_value_regs_i (.i_mclk(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(be), .o_avs_readdata(rdd), .o_avs_waitrequest(wq),
		.o_time_weekday_hour(twh), .o_time_minute_second(tms), .o_alarm_month_day(amd),
		.o_alarm_weekday_hour(awh), .o_alarm_minute_second(ams), .o_weekday_digit(wday),
		.o_hour_tens_digit(ht), .o_hour_ones_digit(ho), .o_minute_tens_digit(mt),
		.o_minute_ones_digit(mo), .o_second_tens_digit(st), .o_second_ones_digit(so),
		.o_clock_write_enable(wen), .o_alarm_window_pointer(ptr));
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [4:0] ad, input logic [15:0] d,
		input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= ad;
		wd <= {16'h0000, d};
		be <= b;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wq !== 1'b0 && n < 50);
		x = rdd[15:0];
		rd <= 1'b0;
		wr <= 1'b0;
		if (wq !== 1'b0)
		begin
			chk(wq, 0);
			print_verdict();
		end
		@(negedge clk);
	endtask : bus
	function automatic logic [15:0] mrg(logic [15:0] o, logic [15:0] d, logic [15:0] m,
		logic [3:0] b);
		logic [15:0] l;
		l = {{8{b[1]}}, {8{b[0]}}};
		return ((o & ~l) | (d & l)) & m;
	endfunction : mrg
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		bus(1, RTV_OFS_CTRL, 16'h0001, 4'h3);
		for (int i = 0; i < 16; i++)
		begin
			v = 16'($random(seed));
			bv = 4'($random(seed));
			bus(1, RTV_OFS_TIME_WH, v, bv);
			tw = mrg(tw, v, RTV_WH_MASK, bv);
			bus(1, RTV_OFS_TIME_MS, ~v, bv);
			tm = mrg(tm, ~v, RTV_MS_MASK, bv);
			bus(0, RTV_OFS_TIME_WH, 16'h0, 4'h3);
			chk(x, tw);
			chk({wday, ht, ho}, {tw[10:8], tw[5:4], tw[3:0]});
			chk({mt, mo}, {tm[14:12], tm[11:8]});
			chk({st, so}, {tm[6:4], tm[3:0]});
			chk(tms, tm);
		end
		$display("time words done");
		bus(1, RTV_OFS_CTRL, 16'h0201, 4'h3);
		for (int i = 2; i >= 0; i--)
		begin
			chk(ptr, i[1:0]);
			a[i] = 16'($random(seed));
			bus(1, RTV_OFS_ALARM_WIN, a[i], 4'h3);
		end
		chk(ptr, 0);
		chk(amd, a[2] & RTV_MD_MASK);
		chk(awh, a[1] & RTV_WH_MASK);
		chk(ams, a[0] & RTV_MS_MASK);
		bus(0, RTV_OFS_ALARM_WIN, 16'h0, 4'h3);
		chk({ptr, x}, {2'h0, a[0] & RTV_MS_MASK});
		bus(1, RTV_OFS_CTRL, 16'h0101, 4'h3);
		bus(0, RTV_OFS_ALARM_WIN, 16'h0, 4'h1);
		chk({ptr, x}, {2'h1, a[1] & RTV_WH_MASK});
		bus(0, RTV_OFS_ALARM_WIN, 16'h0, 4'h2);
		chk({ptr, x}, {2'h0, a[1] & RTV_WH_MASK});
		$display("alarm window done");
		bus(1, RTV_OFS_CTRL, 16'h0200, 4'h3);
		bus(1, RTV_OFS_ALARM_WIN, ~a[2], 4'h3);
		bus(1, RTV_OFS_ALARM_WIN, ~a[1], 4'h3);
		bus(1, RTV_OFS_TIME_WH, ~tw, 4'h3);
		chk({amd, awh}, {a[2] & RTV_MD_MASK, a[1] & RTV_WH_MASK});
		chk(twh, tw);
		chk({wen, ptr}, 3'h0);
		bus(1, RTV_OFS_ALARM_WIN, ~a[0], 4'h3);
		chk(ams, ~a[0] & RTV_MS_MASK);
		$display("write gate done");
		bus(1, RTV_OFS_CTRL, 16'h0300, 4'h3);
		bus(0, RTV_OFS_ALARM_WIN, 16'h0, 4'h3);
		chk(x, 0);
		bus(0, RTV_OFS_CTRL, 16'h0, 4'h3);
		chk({wen, x}, {1'b0, 16'h0200});
		bus(1, RTV_OFS_CTRL, 16'h0001, 4'h1);
		bus(0, RTV_OFS_CTRL, 16'h0, 4'h3);
		chk({wen, x}, {1'b1, 16'h0201});
		bus(0, 5'h10, 16'h0, 4'h3);
		chk(rdd, 0);
		$display("empty places done");
		print_verdict();
	end
endmodule : tb_top
